// *** design/dual_timer_counter.sv ***
// Overview of operation
// - Timer function counts once per machine cycle
// - Counter function samples pin at sample phase
// - Falling edge: 1 then 0 next sample
// - Edge count appears at next-cycle update phase
// - Source bit: 1 counter, 0 timer
// - Gate set: count only while irq pin high
// - Irq pin zero/one gate timer zero/one
// - Mode field: 13-bit, 16-bit, reload, special
// - Timer one special mode stops it
// - Timer zero special mode splits two halves
// - Reset clears whole mode register
// - Timer one flag: set overflow, clear vector
// - Timer zero flag: set overflow, clear vector
// - Run bit enables or disables each timer
// - Reset clears flags and run bits
// - 13-bit: low five bits plus high byte
// - Reset clears all count registers
// - Restart resumes from retained count
// - 13-bit wraps after 1FFF, sets flag
// - 16-bit: high byte over low byte
// - Reload: after FF copy high, set flag
// - Timer one mirrors timer zero behaviour
// - Split high half uses timer one controls
// - During split, timer one free-runs ungated
//
// The APB interface to the registers and the register offsets were left to the implementer.
module dual_timer_counter
   import dual_timer_pkg::*;
(
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input logic count_pin_zero,
   input logic count_pin_one,
   input logic ext_irq_pin_zero,
   input logic ext_irq_pin_one,
   // Interrupt vectoring
   input logic tmr0_vector_ack,
   input logic tmr1_vector_ack,
   output logic tmr0_overflow_flag,
   output logic tmr1_overflow_flag
);

   // Machine-cycle phase and its two strobes
   logic [3:0] phase;
   logic tick_upd, tick_smp;
   // Filtered pin levels: count 0, count 1, gate 0, gate 1
   logic [3:0] lvl;
   // Previous samples and pending edges per timer
   logic [1:0] smp_prev, pend;
   // Software registers
   logic [7:0] timer_mode_select;
   logic tmr0_run_bit, tmr1_run_bit;
   // Count registers
   logic [7:0] tmr0_low_count, tmr0_high_count;
   logic [7:0] tmr1_low_count, tmr1_high_count;
   // Decoded mode fields
   timer_mode_e mode0, mode1;
   logic split0, stop1;
   // Count enables and overflow events
   logic inc0, inc0_hi, inc1;
   logic ovf0, ovf0_hi, ovf1, set0, set1;
   logic [16:0] step0, step1;
   // APB decode
   logic hit, acc_done, wr_en;
   logic wr_mode, wr_run, wr_t0_lo, wr_t0_hi, wr_t1_lo, wr_t1_hi;
   logic [7:0] rd_value;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Divide the clock into twelve-phase machine cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 4'h0;
      end else if (phase == MC_LAST) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end

   assign tick_upd = (phase == UPDATE_PHASE);
   assign tick_smp = (phase == SAMPLE_PHASE);

   a_machine_cycle: assert property
      (tick_upd |-> ##1 (!tick_upd) [*8] ##1 (!tick_upd) [*3] ##1 tick_upd)
      else $error("update strobe not once per machine cycle");

   // Pins arrive asynchronously; all four are synchronised and filtered
   pin_filter #(.WIDTH(4)) u_pins (
      .clk(pclk),
      .rst_n(presetn),
      .pin_in({ext_irq_pin_one, ext_irq_pin_zero, count_pin_one, count_pin_zero}),
      .level(lvl)
   );

   // Edge detection on each count pin, aligned to machine cycles
   for (genvar i = 0; i < 2; i++) begin : g_edge
      logic prev, pnd;

      // Sample once per cycle; edge waits for the next update phase
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            prev <= PIN_IDLE;
            pnd <= 1'b0;
         end else begin
            if (tick_smp) begin
               prev <= lvl[i];
            end
            if (tick_smp && prev && !lvl[i]) begin
               pnd <= 1'b1;
            end else if (tick_upd) begin
               pnd <= 1'b0;
            end
         end
      end

      assign smp_prev[i] = prev;
      assign pend[i] = pnd;
   end

   a_edge_to_update: assert property
      ((tick_smp && smp_prev[0] && !lvl[0]) |-> ##7 (tick_upd && pend[0]))
      else $error("count edge not ready at update phase");

   // Mode register fields
   assign mode0 = timer_mode_e'(timer_mode_select[1:0]);
   assign mode1 = timer_mode_e'(timer_mode_select[NIBBLE+1:NIBBLE]);
   assign split0 = (mode0 == MODE_SPLIT);
   assign stop1 = (mode1 == MODE_SPLIT);

   // Timer zero low part: run, gate on irq pin zero, source select
   assign inc0 = tick_upd && tmr0_run_bit
      && (!timer_mode_select[GATE_BIT] || lvl[2])
      && (!timer_mode_select[SOURCE_BIT] || pend[0]);

   // Split high half counts machine cycles under timer one's run bit
   assign inc0_hi = tick_upd && split0 && tmr1_run_bit;

   // Timer one: free-running while timer zero is split, stopped in mode 3
   always_comb begin
      if (stop1) begin
         inc1 = 1'b0;
      end else if (split0) begin
         inc1 = tick_upd;
      end else begin
         inc1 = tick_upd && tmr1_run_bit
            && (!timer_mode_select[NIBBLE+GATE_BIT] || lvl[3])
            && (!timer_mode_select[NIBBLE+SOURCE_BIT] || pend[1]);
      end
   end

   // One count step: returns {overflow, high, low}
   function automatic logic [16:0] step(input timer_mode_e m, input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [7:0] nl, nh;
      logic ov;
      nl = lo;
      nh = hi;
      ov = 1'b0;
      unique case (m)
         MODE_13BIT: begin
            // Upper three low bits are not part of the count
            nl[4:0] = lo[4:0] + 5'h01;
            nh = (&lo[4:0]) ? hi + 8'h01 : hi;
            ov = (&lo[4:0]) && (&hi);
         end
         MODE_16BIT: begin
            nl = lo + 8'h01;
            nh = (&lo) ? hi + 8'h01 : hi;
            ov = (&lo) && (&hi);
         end
         MODE_RELOAD: begin
            // High byte only feeds the reload, never counts
            nl = (&lo) ? hi : lo + 8'h01;
            ov = &lo;
         end
         MODE_SPLIT: begin
            nl = lo + 8'h01;
            ov = &lo;
         end
      endcase
      return {ov, nh, nl};
   endfunction

   assign step0 = step(mode0, tmr0_low_count, tmr0_high_count);
   assign step1 = step(mode1, tmr1_low_count, tmr1_high_count);
   assign ovf0 = inc0 && step0[16];
   assign ovf0_hi = inc0_hi && (&tmr0_high_count);
   // Timer one raises no flag while its controls are lent out
   assign ovf1 = inc1 && step1[16] && !split0;
   assign set0 = ovf0;
   assign set1 = split0 ? ovf0_hi : ovf1;

   a_timer_step: assert property
      ((inc0 && mode0 == MODE_16BIT && !wr_t0_lo && tmr0_low_count != 8'hFF)
       |=> tmr0_low_count == $past(tmr0_low_count) + 8'h01)
      else $error("16-bit low count did not step by one");

   // Timer zero count registers; a software write wins over a count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr0_low_count <= COUNT_RST;
         tmr0_high_count <= COUNT_RST;
      end else begin
         if (wr_t0_lo) begin
            tmr0_low_count <= pwdata[7:0];
         end else if (inc0) begin
            tmr0_low_count <= step0[7:0];
         end
         if (wr_t0_hi) begin
            tmr0_high_count <= pwdata[7:0];
         end else if (inc0_hi) begin
            tmr0_high_count <= tmr0_high_count + 8'h01;
         end else if (inc0 && !split0) begin
            tmr0_high_count <= step0[15:8];
         end
      end
   end

   a_wrap_13bit: assert property
      ((inc0 && mode0 == MODE_13BIT && (&tmr0_high_count) && (&tmr0_low_count[4:0])
        && !wr_t0_lo && !wr_t0_hi)
       |=> tmr0_high_count == 8'h00 && tmr0_low_count[4:0] == 5'h00
           && tmr0_overflow_flag)
      else $error("13-bit count did not wrap with flag");

   a_reload: assert property
      ((inc0 && mode0 == MODE_RELOAD && (&tmr0_low_count) && !wr_t0_lo && !wr_t0_hi)
       |=> tmr0_low_count == $past(tmr0_high_count) && $stable(tmr0_high_count)
           && tmr0_overflow_flag)
      else $error("reload from high byte missing");

   a_split_high: assert property
      ((inc0_hi && (&tmr0_high_count) && !wr_t0_hi)
       |=> tmr0_high_count == 8'h00 && tmr1_overflow_flag)
      else $error("split high half overflow not flagged on timer one");

   a_gate_hold: assert property
      ((tick_upd && timer_mode_select[GATE_BIT] && !lvl[2] && !split0
        && !wr_t0_lo && !wr_t0_hi)
       |=> $stable(tmr0_low_count) && $stable(tmr0_high_count))
      else $error("gated timer counted with gate pin low");

   a_run_hold: assert property
      ((!tmr0_run_bit && !split0 && !wr_t0_lo && !wr_t0_hi)
       |=> $stable(tmr0_low_count) && $stable(tmr0_high_count))
      else $error("stopped timer zero changed its count");

   // Timer one count registers, same structure as timer zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr1_low_count <= COUNT_RST;
         tmr1_high_count <= COUNT_RST;
      end else begin
         if (wr_t1_lo) begin
            tmr1_low_count <= pwdata[7:0];
         end else if (inc1) begin
            tmr1_low_count <= step1[7:0];
         end
         if (wr_t1_hi) begin
            tmr1_high_count <= pwdata[7:0];
         end else if (inc1) begin
            tmr1_high_count <= step1[15:8];
         end
      end
   end

   a_t1_stopped: assert property
      ((stop1 && !wr_t1_lo && !wr_t1_hi)
       |=> $stable(tmr1_low_count) && $stable(tmr1_high_count))
      else $error("timer one counted in stopped mode");

   // Mode register, written only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_select <= MODE_SELECT_RST;
      end else if (wr_mode) begin
         timer_mode_select <= pwdata[7:0];
      end
   end

   // Run bits, written only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr0_run_bit <= 1'b0;
         tmr1_run_bit <= 1'b0;
      end else if (wr_run) begin
         tmr0_run_bit <= pwdata[TR0_BIT];
         tmr1_run_bit <= pwdata[TR1_BIT];
      end
   end

   // Overflow flags; an overflow in the clearing cycle is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr0_overflow_flag <= 1'b0;
         tmr1_overflow_flag <= 1'b0;
      end else begin
         if (set0) begin
            tmr0_overflow_flag <= 1'b1;
         end else if (wr_run) begin
            tmr0_overflow_flag <= pwdata[TF0_BIT];
         end else if (tmr0_vector_ack) begin
            tmr0_overflow_flag <= 1'b0;
         end
         if (set1) begin
            tmr1_overflow_flag <= 1'b1;
         end else if (wr_run) begin
            tmr1_overflow_flag <= pwdata[TF1_BIT];
         end else if (tmr1_vector_ack) begin
            tmr1_overflow_flag <= 1'b0;
         end
      end
   end

   a_flag_set_wins: assert property
      ((ovf0 && tmr0_vector_ack) |=> tmr0_overflow_flag)
      else $error("overflow lost against vector clear");

   a_flag_ack: assert property
      ((tmr1_overflow_flag && tmr1_vector_ack && !set1 && !wr_run)
       |=> !tmr1_overflow_flag)
      else $error("timer one flag not cleared on vector");

   // APB address decode; only byte lane 0 carries register data
   always_comb begin
      hit = 1'b1;
      rd_value = 8'h00;
      unique case (paddr)
         ADDR_MODE_SELECT: rd_value = timer_mode_select;
         ADDR_RUN_FLAGS: begin
            rd_value[TF1_BIT] = tmr1_overflow_flag;
            rd_value[TR1_BIT] = tmr1_run_bit;
            rd_value[TF0_BIT] = tmr0_overflow_flag;
            rd_value[TR0_BIT] = tmr0_run_bit;
         end
         ADDR_T0_LOW: rd_value = tmr0_low_count;
         ADDR_T0_HIGH: rd_value = tmr0_high_count;
         ADDR_T1_LOW: rd_value = tmr1_low_count;
         ADDR_T1_HIGH: rd_value = tmr1_high_count;
         default: hit = 1'b0;
      endcase
   end

   assign acc_done = psel && penable && pready;
   assign wr_en = acc_done && pwrite && hit && pstrb[0];
   assign wr_mode = wr_en && (paddr == ADDR_MODE_SELECT);
   assign wr_run = wr_en && (paddr == ADDR_RUN_FLAGS);
   assign wr_t0_lo = wr_en && (paddr == ADDR_T0_LOW);
   assign wr_t0_hi = wr_en && (paddr == ADDR_T0_HIGH);
   assign wr_t1_lo = wr_en && (paddr == ADDR_T1_LOW);
   assign wr_t1_hi = wr_en && (paddr == ADDR_T1_HIGH);

   // One wait state so that read data comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !hit;
         prdata <= (hit && !pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   a_apb_answer: assert property
      ((psel && penable && !pready) |=> (pready && pslverr == $past(!hit)))
      else $error("APB answer not one cycle after access");

   // Main scenarios
   c_reload: cover property (inc0 && mode0 == MODE_RELOAD && (&tmr0_low_count));
   c_wrap_13bit: cover property (ovf0 && mode0 == MODE_13BIT);
   c_split_overflow: cover property (ovf0_hi);
   c_edge_counted: cover property (inc0 && timer_mode_select[SOURCE_BIT]);

endmodule // dual_timer_counter

// *** design/dual_timer_pkg.sv ***
package dual_timer_pkg;

   // Clock cycles per machine cycle
   localparam int MC_LEN = 12;
   // Last phase index of a machine cycle
   localparam logic [3:0] MC_LAST = 4'(MC_LEN - 1);
   // Phase at which counts become visible
   localparam logic [3:0] UPDATE_PHASE = 4'h4;
   // Phase at which count pins are sampled
   localparam logic [3:0] SAMPLE_PHASE = 4'h9;

   // Register byte offsets on the APB
   localparam logic [7:0] ADDR_MODE_SELECT = 8'h00;
   localparam logic [7:0] ADDR_RUN_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_T0_LOW = 8'h08;
   localparam logic [7:0] ADDR_T0_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_T1_LOW = 8'h10;
   localparam logic [7:0] ADDR_T1_HIGH = 8'h14;

   // Values after reset
   localparam logic [7:0] MODE_SELECT_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic PIN_IDLE = 1'b1;

   // Bit positions in the run and flag register
   localparam int TF1_BIT = 7;
   localparam int TR1_BIT = 6;
   localparam int TF0_BIT = 5;
   localparam int TR0_BIT = 4;

   // Offset of timer one's nibble, and bit positions inside one timer's mode nibble
   localparam int NIBBLE = 4;
   localparam int GATE_BIT = 3;
   localparam int SOURCE_BIT = 2;

   // Operating modes of one timer
   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } timer_mode_e;

endpackage

// *** design/pin_filter.sv ***
module pin_filter
   import dual_timer_pkg::*;
#(
   parameter int WIDTH = 4
)(
   // Clock and reset
   input logic clk,
   input logic rst_n,
   // Raw pins and their filtered levels
   input logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);

   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      // Three-stage chain; stage one is only read by stage two
      logic s1, s2, s3;

      // Shift the pin in
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
         end else begin
            s1 <= pin_in[i];
            s2 <= s1;
            s3 <= s2;
         end
      end

      // A change counts only once two stages agree, rejecting runts
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            level[i] <= PIN_IDLE;
         end else if (s2 == s3) begin
            level[i] <= s3;
         end
      end
   end

endmodule // pin_filter

// *** sim/dual_timer_counter_test.sv ***
module dual_timer_counter_test
   import dual_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // Clock, reset and APB
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   // Pins, acknowledges and flags
   logic count_pin_zero, count_pin_one, ext_irq_pin_zero, ext_irq_pin_one;
   logic tmr0_vector_ack, tmr1_vector_ack, tmr0_overflow_flag, tmr1_overflow_flag;
   // Partner control
   logic go, gate_zero, gate_one, busy;
   logic [7:0] n_edges;
   // Bookkeeping
   int n_fail = 0;
   int tests_run = 0;
   logic [1:0] flags; // Flags seen just before a timed run stops
   logic [31:0] rdat;
   logic rerr;
   logic [7:0] v;

   dual_timer_counter i_dual_timer_counter (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin_zero(count_pin_zero),
      .count_pin_one(count_pin_one), .ext_irq_pin_zero(ext_irq_pin_zero),
      .ext_irq_pin_one(ext_irq_pin_one), .tmr0_vector_ack(tmr0_vector_ack),
      .tmr1_vector_ack(tmr1_vector_ack), .tmr0_overflow_flag(tmr0_overflow_flag),
      .tmr1_overflow_flag(tmr1_overflow_flag));

   pin_source i_pin_source (.pclk(pclk), .go(go), .n_edges(n_edges), .gate_zero(gate_zero),
      .gate_one(gate_one), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
      .ext_irq_pin_zero(ext_irq_pin_zero), .ext_irq_pin_one(ext_irq_pin_one), .busy(busy));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Print counts and verdict, then stop
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One APB transfer; always entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, a, 24'h0, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      // Idle cycle, so a following call never reassigns psel in the same step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'hF, rdat, rerr);
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read a register and compare the bits under the mask; upper bits must read 0
   task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 8'h00, 4'h0, rdat, rerr);
      cmp(rdat & {24'hFFFFFF, m}, {24'h0, e & m});
   endtask

   task automatic chk_zero();
      for (int i = 0; i < 6; i++) chk(ADDR_MODE_SELECT + 8'(4 * i), 8'hFF, 8'h00);
   endtask

   // Run for exactly mcs machine cycles between the two run-register updates
   task automatic span(input logic [7:0] run, input int mcs);
      wr(ADDR_RUN_FLAGS, run);
      repeat (12 * mcs - 4) @(posedge pclk);
      flags = {tmr1_overflow_flag, tmr0_overflow_flag};
      // Stop both timers but write the flags back, so the stop does not hide them
      wr(ADDR_RUN_FLAGS, {flags[1], 1'b0, flags[0], 5'h00});
   endtask

   // Preload, select a mode, run, then check counts, flags and their clearing
   task automatic scen(input logic [7:0] mode, input logic [31:0] pre, input logic [7:0] run,
         input int mcs, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] ef);
      for (int i = 0; i < 4; i++) wr(ADDR_T0_LOW + 8'(4 * i), pre[8 * i +: 8]);
      wr(ADDR_MODE_SELECT, mode);
      chk(ADDR_MODE_SELECT, 8'hFF, mode);
      span(run, mcs);
      for (int i = 0; i < 4; i++) chk(ADDR_T0_LOW + 8'(4 * i), m[8 * i +: 8], exp[8 * i +: 8]);
      cmp(32'(flags), 32'(ef));
      chk(ADDR_RUN_FLAGS, 8'hFF, {ef[1], 1'b0, ef[0], 5'h00});
      {tmr1_vector_ack, tmr0_vector_ack} <= 2'b11;
      @(posedge pclk);
      {tmr1_vector_ack, tmr0_vector_ack} <= 2'b00;
      repeat (2) @(posedge pclk);
      cmp(32'({tmr1_overflow_flag, tmr0_overflow_flag}), 32'h0);
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {tmr0_vector_ack, tmr1_vector_ack, go, n_edges} = '0;
      {gate_zero, gate_one} = 2'b11;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_zero();
      // Unmapped address is refused; a write without byte strobe is ignored
      apb(1'b0, 8'h18, 8'h00, 4'h0, rdat, rerr);
      cmp(rdat, 32'h0);
      cmp(32'(rerr), 32'h1);
      apb(1'b1, ADDR_MODE_SELECT, 8'h77, 4'h0, rdat, rerr);
      chk(ADDR_MODE_SELECT, 8'hFF, 8'h00);
      scen(8'h01, 32'h0000_FFFE, 8'h10, 3, 32'h0000_0001, '1, 2'b01);
      scen(8'h00, 32'h0000_FF1E, 8'h10, 3, 32'h0000_0001, '1, 2'b01);
      span(8'h10, 2);
      chk(ADDR_T0_LOW, 8'hFF, 8'h03);
      scen(8'h10, 32'hFFFE_0000, 8'h40, 3, 32'h0001_0000, '1, 2'b10);
      scen(8'h20, 32'hF0FE_0000, 8'h40, 3, 32'hF0F1_0000, '1, 2'b10);
      scen(8'h02, 32'h0000_F0FE, 8'h10, 3, 32'h0000_F0F1, '1, 2'b01);
      scen(8'h30, 32'h0705_0000, 8'h40, 4, 32'h0705_0000, '1, 2'b00);
      scen(8'h33, 32'h0010_00FF, 8'h10, 2, 32'h0010_0001, '1, 2'b01);
      scen(8'h13, 32'h0010_FE00, 8'h50, 3, 32'h0000_0103, 32'hFFFF, 2'b10);
      // Timer 1 keeps counting machine cycles while timer 0 is split, run bit off
      apb(1'b0, ADDR_T1_LOW, 8'h00, 4'h0, rdat, rerr);
      v = rdat[7:0];
      repeat (116) @(posedge pclk);
      apb(1'b0, ADDR_T1_LOW, 8'h00, 4'h0, rdat, rerr);
      cmp(32'(rdat[7:0] - v), 32'h0A);
      // Counter function: five falling edges on both count pins
      wr(ADDR_MODE_SELECT, 8'h55);
      for (int i = 0; i < 4; i++) wr(ADDR_T0_LOW + 8'(4 * i), 8'h00);
      wr(ADDR_RUN_FLAGS, 8'h50);
      {n_edges, go} <= {8'd5, 1'b1};
      @(posedge pclk);
      go <= 1'b0;
      repeat (2) @(posedge pclk);
      for (int k = 0; k < 1000 && busy === 1'b1; k++) @(posedge pclk);
      // Allow for the pending count still in flight
      repeat (48) @(posedge pclk);
      wr(ADDR_RUN_FLAGS, 8'h00);
      chk(ADDR_T0_LOW, 8'hFF, 8'h05);
      chk(ADDR_T1_LOW, 8'hFF, 8'h05);
      // Gated counting: only the timer whose gate pin is high advances
      for (int g = 0; g < 2; g++) begin
         gate_zero <= g[0];
         gate_one <= ~g[0];
         repeat (8) @(posedge pclk);
         scen(8'h99, 32'h0, 8'h50, 6, g ? 32'h6 : 32'h0006_0000, '1, 2'b00);
      end
      // Reset in mid-run clears everything
      wr(ADDR_MODE_SELECT, 8'h5A);
      wr(ADDR_RUN_FLAGS, 8'h50);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_zero();
      complete_run();
   end

   // Watchdog well beyond the roughly 1500 cycles the sequence needs
   initial begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      complete_run();
   end
endmodule // dual_timer_counter_test

// *** sim/pin_source.sv ***
module pin_source (
   // Clock
   input wire logic pclk,
   // Burst request and gate levels from the bench
   input wire logic go,
   input wire logic [7:0] n_edges,
   input wire logic gate_zero,
   input wire logic gate_one,
   // Pins seen by the timer block, and the burst status for the bench
   output logic count_pin_zero,
   output logic count_pin_one,
   output logic ext_irq_pin_zero,
   output logic ext_irq_pin_one,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;

   // Each level lasts two machine cycles, so every level is sampled at least once
   initial begin
      count_pin_zero = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge pclk);
         if (go === 1'b1) begin
            busy <= 1'b1;
            repeat (n_edges) begin
               repeat (24) @(posedge pclk);
               count_pin_zero <= 1'b0;
               repeat (24) @(posedge pclk);
               count_pin_zero <= 1'b1;
            end
            busy <= 1'b0;
         end
      end
   end

   // Both timers see the same pulse train; the line rests high between bursts
   assign count_pin_one = count_pin_zero;
   // Gate pins follow the requested levels
   assign ext_irq_pin_zero = gate_zero;
   assign ext_irq_pin_one = gate_one;
endmodule // pin_source
